// File: core/tcs_map.vh
// Constants for the tick clock scheduler: register offsets, fields, reset values, counts.
// Assumes byte addresses on a 12-bit register port with 32-bit data.
`ifndef TCS_MAP_VH
`define TCS_MAP_VH

// Register offsets
`define TCS_REG_TIME 12'h000
`define TCS_REG_TICK 12'h004
`define TCS_REG_CTRL 12'h008
`define TCS_REG_BTN 12'h00C
`define TCS_REG_REQ 12'h010
`define TCS_REG_STAT 12'h014
`define TCS_STORE_PAGE 4'h1
`define TCS_STORE_BYTES 6'd48

// Field positions in the time register
`define TCS_TIME_SEC_LSB 0
`define TCS_TIME_MIN_LSB 8
`define TCS_TIME_HOUR_LSB 16
`define TCS_TIME_PM_BIT 24

// Field positions in the schedule store bytes and the control register
`define TCS_ON_PM_BIT 7
`define TCS_OFF_PM_BIT 6
`define TCS_DAWN_OFF_BIT 6
`define TCS_CTRL_RUN_BIT 0

// Reset values
`define TCS_CTRL_RESET 1'b1
`define TCS_HOUR_RESET 4'hC
`define TCS_TICK_RESET 16'hFCE0

// Counting
`define TCS_TICK_RELOAD 16'hFCE0
`define TCS_TICK_MAX 16'hFFFF
`define TCS_TICKS_PER_SEC 6'd40
`define TCS_SEC_LAST 6'd59
`define TCS_MIN_LAST 6'd59
`define TCS_HOUR_LAST 4'hC
`define TCS_HOUR_FIRST 4'h1
`define TCS_HOUR_PM_FLIP 4'hB
`define TCS_UNIT_LAST 4'hF

`endif

// File: core/tcs_sched_store.v
// Packed schedule store: 48 bytes held in flip-flops, three rows of 16 units.
// Assumes the caller checks that the write index is below 48.
`timescale 1ns/100ps
`include "tcs_map.vh"

module tcs_sched_store (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Byte port
    input wire wr_en,
    input wire [5:0] wr_idx,
    input wire [7:0] wr_data,
    input wire [5:0] rd_idx,
    output wire [7:0] rd_data,
    // Unit record port
    input wire [3:0] unit_idx,
    output wire [7:0] hour_byte,
    output wire [7:0] on_min_byte,
    output wire [7:0] off_min_byte
);
    wire [383:0] mem_w;

    genvar g;
    generate
        for (g = 0; g < 48; g = g + 1) begin : entry
            reg [7:0] byte_ff;
            always @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    byte_ff <= 8'h00;
                end else if (wr_en && (wr_idx == g[5:0])) begin
                    byte_ff <= wr_data;
                end
            end
            assign mem_w[g*8 +: 8] = byte_ff;
        end
    endgenerate

    // Unit rows: hours at 0..15, on minutes at 16..31, off minutes at 32..47
    assign rd_data = mem_w[{rd_idx, 3'b000} +: 8];
    assign hour_byte = mem_w[{2'b00, unit_idx, 3'b000} +: 8];
    assign on_min_byte = mem_w[{2'b01, unit_idx, 3'b000} +: 8];
    assign off_min_byte = mem_w[{2'b10, unit_idx, 3'b000} +: 8];
endmodule

// File: core/tcs_top.v
// Tick clock scheduler: crystal tick counter, button debounce, time of day,
// schedule comparison and switch requests.
// Assumes a free-running 32 kHz crystal input and five active-low buttons.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "tcs_map.vh"

module tcs_top (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Crystal and pins
    input wire xtal_32k,
    input wire [4:0] button_input_lines_n,
    input wire dawn_detect,
    // Register port
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [31:0] reg_rdata,
    // Status outputs
    output wire tick_irq,
    output wire [4:0] btn_pressed,
    output wire [15:0] on_req,
    output wire [15:0] off_req
);
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_SCAN = 2'b10;

    // Pin synchronisers
    reg [2:0] xtal_sync_ff;
    reg [4:0] btn_meta_ff;
    reg [4:0] btn_sync_ff;
    reg dawn_meta_ff;
    reg [1:0] dawn_sync_ff;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            xtal_sync_ff <= 3'h0;
            btn_meta_ff <= 5'h1F;
            btn_sync_ff <= 5'h1F;
            dawn_meta_ff <= 1'b0;
            dawn_sync_ff <= 2'h0;
        end else begin
            xtal_sync_ff <= {xtal_sync_ff[1:0], xtal_32k};
            btn_meta_ff <= button_input_lines_n;
            btn_sync_ff <= btn_meta_ff;
            dawn_meta_ff <= dawn_detect;
            dawn_sync_ff <= {dawn_sync_ff[0], dawn_meta_ff};
        end
    end

    // Stage 2 and 3 form the edge detector; stage 1 only feeds stage 2
    wire xtal_rise = xtal_sync_ff[1] & ~xtal_sync_ff[2];
    wire dawn_rise = dawn_sync_ff[0] & ~dawn_sync_ff[1];

    // Register decode
    wire store_hit = (reg_addr[11:8] == `TCS_STORE_PAGE) && (reg_addr[1:0] == 2'b00)
                     && (reg_addr[7:2] < `TCS_STORE_BYTES);
    wire wr_time = reg_wr && (reg_addr == `TCS_REG_TIME);
    wire wr_tick = reg_wr && (reg_addr == `TCS_REG_TICK);
    wire wr_ctrl = reg_wr && (reg_addr == `TCS_REG_CTRL);
    wire wr_req = reg_wr && (reg_addr == `TCS_REG_REQ);
    wire wr_store = reg_wr && store_hit;

    // Tick counter on crystal edges
    reg ctrl_run_ff;
    reg [15:0] tick_counter_pair_ff;
    reg tick_irq_ff;
    reg [15:0] nxt_tick_counter_pair;
    reg nxt_tick_irq;
    wire tick_overflow = xtal_rise && ctrl_run_ff && (tick_counter_pair_ff == `TCS_TICK_MAX);

    always @* begin
        nxt_tick_counter_pair = tick_counter_pair_ff;
        nxt_tick_irq = 1'b0;
        if (wr_tick) begin
            nxt_tick_counter_pair = reg_wdata[15:0];
        end else if (tick_overflow) begin
            nxt_tick_counter_pair = `TCS_TICK_RELOAD;
            nxt_tick_irq = 1'b1;
        end else if (xtal_rise && ctrl_run_ff) begin
            nxt_tick_counter_pair = tick_counter_pair_ff + 16'h0001;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_run_ff <= `TCS_CTRL_RESET;
            tick_counter_pair_ff <= `TCS_TICK_RESET;
            tick_irq_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_run_ff <= reg_wdata[`TCS_CTRL_RUN_BIT];
            end
            tick_counter_pair_ff <= nxt_tick_counter_pair;
            tick_irq_ff <= nxt_tick_irq;
        end
    end

    // Button scan: one sample per tick, accept when two samples agree
    reg [4:0] btn_prev_ff;
    reg [4:0] btn_state_ff;
    reg scan_done_ff;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            btn_prev_ff <= 5'h1F;
            btn_state_ff <= 5'h00;
            scan_done_ff <= 1'b0;
        end else begin
            scan_done_ff <= tick_irq_ff;
            if (tick_irq_ff) begin
                btn_prev_ff <= btn_sync_ff;
                if (btn_prev_ff == btn_sync_ff) begin
                    btn_state_ff <= ~btn_sync_ff;
                end
            end
        end
    end

    // Time of day, advanced after each scan
    reg [5:0] tick_cnt_ff;
    reg [5:0] sec_ff;
    reg [5:0] min_ff;
    reg [3:0] hour_ff;
    reg pm_ff;
    reg [5:0] nxt_tick_cnt;
    reg [5:0] nxt_sec;
    reg [5:0] nxt_min;
    reg [3:0] nxt_hour;
    reg nxt_pm;
    reg min_step;

    always @* begin
        nxt_tick_cnt = tick_cnt_ff;
        nxt_sec = sec_ff;
        nxt_min = min_ff;
        nxt_hour = hour_ff;
        nxt_pm = pm_ff;
        min_step = 1'b0;
        if (wr_time) begin
            nxt_tick_cnt = 6'h00;
            nxt_sec = reg_wdata[`TCS_TIME_SEC_LSB +: 6];
            nxt_min = reg_wdata[`TCS_TIME_MIN_LSB +: 6];
            nxt_hour = reg_wdata[`TCS_TIME_HOUR_LSB +: 4];
            nxt_pm = reg_wdata[`TCS_TIME_PM_BIT];
        end else if (scan_done_ff) begin
            nxt_tick_cnt = tick_cnt_ff + 6'h01;
            if (nxt_tick_cnt == `TCS_TICKS_PER_SEC) begin
                nxt_tick_cnt = 6'h00;
                nxt_sec = sec_ff + 6'h01;
                if (sec_ff == `TCS_SEC_LAST) begin
                    nxt_sec = 6'h00;
                    nxt_min = min_ff + 6'h01;
                    min_step = 1'b1;
                    if (min_ff == `TCS_MIN_LAST) begin
                        nxt_min = 6'h00;
                        nxt_hour = hour_ff + 4'h1;
                        if (hour_ff == `TCS_HOUR_LAST) begin
                            nxt_hour = `TCS_HOUR_FIRST;
                        end
                        if (hour_ff == `TCS_HOUR_PM_FLIP) begin
                            nxt_pm = ~pm_ff;
                        end
                    end
                end
            end
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_ff <= 6'h00;
            sec_ff <= 6'h00;
            min_ff <= 6'h00;
            hour_ff <= `TCS_HOUR_RESET;
            pm_ff <= 1'b0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            sec_ff <= nxt_sec;
            min_ff <= nxt_min;
            hour_ff <= nxt_hour;
            pm_ff <= nxt_pm;
        end
    end

    // Schedule store
    reg [3:0] unit_ff;
    wire [7:0] store_rd;
    wire [7:0] hour_byte;
    wire [7:0] on_min_byte;
    wire [7:0] off_min_byte;

    tcs_sched_store u_store (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wr_en(wr_store),
        .wr_idx(reg_addr[7:2]),
        .wr_data(reg_wdata[7:0]),
        .rd_idx(reg_addr[7:2]),
        .rd_data(store_rd),
        .unit_idx(unit_ff),
        .hour_byte(hour_byte),
        .on_min_byte(on_min_byte),
        .off_min_byte(off_min_byte)
    );

    // Comparison pass, one unit per cycle
    reg [1:0] state_ff;
    reg cmp_pend_ff;
    reg [15:0] on_req_ff;
    reg [15:0] off_req_ff;
    reg [15:0] dawn_sel_ff;
    reg [1:0] nxt_state;
    reg [15:0] set_on;
    reg [15:0] set_off;

    wire on_match = (hour_byte[7:4] == hour_ff) && (on_min_byte[5:0] == min_ff)
                    && (on_min_byte[`TCS_ON_PM_BIT] == pm_ff);
    wire off_match = (hour_byte[3:0] == hour_ff) && (off_min_byte[5:0] == min_ff)
                     && (on_min_byte[`TCS_OFF_PM_BIT] == pm_ff);

    always @* begin
        nxt_state = state_ff;
        set_on = 16'h0000;
        set_off = 16'h0000;
        case (state_ff)
            ST_IDLE: begin
                if (cmp_pend_ff) begin
                    nxt_state = ST_SCAN;
                end
            end
            ST_SCAN: begin
                set_on[unit_ff] = on_match;
                set_off[unit_ff] = off_match;
                if (unit_ff == `TCS_UNIT_LAST) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Dawn edge turns off every unit whose dawn-off bit, shadowed from the store, is set
    wire [15:0] dawn_off = {16{dawn_rise}} & dawn_sel_ff;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            cmp_pend_ff <= 1'b0;
            unit_ff <= 4'h0;
            on_req_ff <= 16'h0000;
            off_req_ff <= 16'h0000;
            dawn_sel_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            if (min_step) begin
                cmp_pend_ff <= 1'b1;
            end else if ((state_ff == ST_IDLE) && cmp_pend_ff) begin
                cmp_pend_ff <= 1'b0;
            end
            if (state_ff == ST_SCAN) begin
                unit_ff <= unit_ff + 4'h1;
            end else begin
                unit_ff <= 4'h0;
            end
            // Write one clears; a same-cycle set wins
            on_req_ff <= (on_req_ff & ~({16{wr_req}} & reg_wdata[15:0])) | set_on;
            off_req_ff <= (off_req_ff & ~({16{wr_req}} & reg_wdata[31:16]))
                          | set_off | dawn_off;
            if (wr_store && (reg_addr[7:6] == 2'b10)) begin
                dawn_sel_ff[reg_addr[5:2]] <= reg_wdata[`TCS_DAWN_OFF_BIT];
            end
        end
    end

    // Read data, one cycle after the strobe
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;

    always @* begin
        nxt_rdata = 32'h00000000;
        if (reg_rd) begin
            if (store_hit) begin
                nxt_rdata = {24'h000000, store_rd};
            end else begin
                case (reg_addr)
                    `TCS_REG_TIME: nxt_rdata = {7'h00, pm_ff, 4'h0, hour_ff, 2'h0, min_ff,
                                                2'h0, sec_ff};
                    `TCS_REG_TICK: nxt_rdata = {10'h000, tick_cnt_ff, tick_counter_pair_ff};
                    `TCS_REG_CTRL: nxt_rdata = {31'h00000000, ctrl_run_ff};
                    `TCS_REG_BTN: nxt_rdata = {27'h0000000, btn_state_ff};
                    `TCS_REG_REQ: nxt_rdata = {off_req_ff, on_req_ff};
                    `TCS_REG_STAT: nxt_rdata = {30'h00000000, state_ff[1], cmp_pend_ff};
                    default: nxt_rdata = 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign tick_irq = tick_irq_ff;
    assign btn_pressed = btn_state_ff;
    assign on_req = on_req_ff;
    assign off_req = off_req_ff;
endmodule

// File: sim/tcs_top_sva.sv
// Port assertions for the tick clock scheduler.
// Assumes binding onto tcs_top; one clock, asynchronous active-low reset.
`timescale 1ns/100ps

module tcs_top_chk (
    // Clock and reset
    input logic sys_clk,
    input logic resetn,
    // Crystal
    input logic xtal_32k,
    // Register port
    input logic [11:0] reg_addr,
    input logic reg_wr,
    input logic reg_rd,
    input logic [31:0] reg_rdata,
    // Status
    input logic tick_irq,
    input logic [4:0] btn_pressed,
    input logic [15:0] on_req,
    input logic [15:0] off_req
);
    logic xtal_ff;
    logic [3:0] rise_age_ff;
    logic [5:0] irq_age_ff;

    // Cycles since the last crystal rise and since the last tick
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            xtal_ff <= 1'b0;
            rise_age_ff <= 4'hF;
            irq_age_ff <= 6'h3F;
        end else begin
            xtal_ff <= xtal_32k;
            rise_age_ff <= (xtal_32k && !xtal_ff) ? 4'h0
                           : rise_age_ff + {3'h0, rise_age_ff != 4'hF};
            irq_age_ff <= tick_irq ? 6'h0 : irq_age_ff + {5'h0, irq_age_ff != 6'h3F};
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_req_clear;
        $past(reg_wr) && $past(reg_addr) == 12'h010;
    endsequence

    sequence s_recent_tick;
        $past(tick_irq) || $past(tick_irq, 2);
    endsequence

    sequence s_rd_past_store;
        reg_rd && reg_addr == 12'h1C0;
    endsequence

    a_irq_pulse: assert property (tick_irq |=> !tick_irq)
        else $error("tick pulse longer than one cycle");
    a_irq_from_xtal: assert property (tick_irq |-> rise_age_ff <= 4'h6)
        else $error("tick without a recent crystal edge");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside the read answer cycle");
    a_store_bound: assert property (s_rd_past_store |=> reg_rdata == 32'h0)
        else $error("read past the 48 store bytes not zero");
    a_btn_on_tick: assert property ($changed(btn_pressed) |-> s_recent_tick)
        else $error("buttons changed away from a tick");
    a_on_clear: assert property (|($past(on_req) & ~on_req) |-> s_req_clear)
        else $error("on request dropped without a clear");
    a_off_clear: assert property (|($past(off_req) & ~off_req) |-> s_req_clear)
        else $error("off request dropped without a clear");
    a_on_after_tick: assert property (|(on_req & ~$past(on_req)) |-> irq_age_ff <= 6'h1E)
        else $error("on request set away from a minute step");
endmodule

bind tcs_top tcs_top_chk u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .xtal_32k(xtal_32k), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_irq(tick_irq),
    .btn_pressed(btn_pressed), .on_req(on_req), .off_req(off_req)
);

// File: sim/tcs_pins_model.sv
// Crystal and push-button model for the tick clock scheduler.
// Assumes the bench sets which buttons are held down.
`timescale 1ns/100ps

module tcs_pins_model (
    // Buttons held
    input logic [4:0] press_mask,
    // Pins
    output logic xtal_32k,
    output logic [4:0] button_input_lines_n
);
    // Crystal sped up to a 64 ns period so that a tick fits the run
    initial begin
        xtal_32k = 1'b0;
        #5;
        forever #32 xtal_32k = ~xtal_32k;
    end

    assign button_input_lines_n = ~press_mask;
endmodule

// File: sim/tcs_top_bench.sv
// Self-checking bench for the tick clock scheduler.
// Assumes tcs_top and the pin model; registers reached over the plain port.
`timescale 1ns/100ps
`include "tcs_map.vh"

module tcs_top_bench;
    logic sys_clk;
    logic resetn;
    logic xtal_32k;
    logic [4:0] press_mask;
    logic [4:0] btn_n;
    logic dawn_detect;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic tick_irq;
    logic [4:0] btn_pressed;
    logic [15:0] on_req;
    logic [15:0] off_req;
    logic [31:0] v;
    logic [31:0] w;
    int n_mismatch;
    int checks;
    int cycles;
    int n;

    tcs_top DUT (
        .sys_clk(sys_clk), .resetn(resetn), .xtal_32k(xtal_32k), .button_input_lines_n(btn_n),
        .dawn_detect(dawn_detect), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_irq(tick_irq),
        .btn_pressed(btn_pressed), .on_req(on_req), .off_req(off_req)
    );
    tcs_pins_model u_pins (
        .press_mask(press_mask), .xtal_32k(xtal_32k), .button_input_lines_n(btn_n)
    );

    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic st(input logic [5:0] i, input logic [7:0] b);
        wr({4'h1, i, 2'h0}, {24'h0, b});
    endtask

    // Waits for the next tick, counting crystal rises on the way
    task automatic wait_irq(output int nr);
        int k;
        logic xq;
        nr = 0;
        k = 0;
        xq = xtal_32k;
        do begin
            @(posedge sys_clk);
            #1;
            if (xtal_32k && !xq)
                nr++;
            xq = xtal_32k;
            k++;
        end while (tick_irq !== 1'b1 && k < 8000);
        if (k == 8000)
            check(32'h0, 32'h1);
    endtask

    task automatic tick_once();
        wr(`TCS_REG_TICK, 32'h0000FFFF);
        wait_irq(n);
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic t_reset();
        rd(`TCS_REG_TIME, v);
        check(v, 32'h000C0000);
        rd(`TCS_REG_REQ, v);
        check(v, 32'h0);
        rd(12'h1C0, v);
        check(v, 32'h0);
        wr(`TCS_REG_CTRL, 32'h0);
        rd(`TCS_REG_TICK, v);
        check({31'h0, v[15:0] - `TCS_TICK_RESET < 16'h8}, 32'h1);
        repeat (50) @(posedge sys_clk);
        rd(`TCS_REG_TICK, w);
        check(w, v);
        wr(`TCS_REG_CTRL, 32'h1);
        repeat (50) @(posedge sys_clk);
        rd(`TCS_REG_TICK, w);
        check({31'h0, w[15:0] != v[15:0]}, 32'h1);
    endtask

    task automatic t_period();
        wr(`TCS_REG_TICK, 32'h0000FFFF);
        wait_irq(n);
        wait_irq(n);
        check(n, 32'h10000 - `TCS_TICK_RELOAD);
        rd(`TCS_REG_TICK, v);
        check({31'h0, v[15:0] - `TCS_TICK_RELOAD < 16'h4}, 32'h1);
    endtask

    task automatic t_cascade();
        st(6'h03, 8'hC0);
        st(6'h13, 8'h80);
        st(6'h05, 8'h0C);
        st(6'h15, 8'h40);
        rd(12'h10C, v);
        check(v, 32'h000000C0);
        wr(`TCS_REG_TIME, 32'h000B3B3B);
        repeat (39) tick_once();
        rd(`TCS_REG_TIME, v);
        check(v, 32'h000B3B3B);
        tick_once();
        rd(`TCS_REG_TIME, v);
        check(v, 32'h010C0000);
        // The minute step has just started a comparison pass
        rd(`TCS_REG_STAT, v);
        check(v, 32'h2);
        repeat (30) @(posedge sys_clk);
        check({16'h0, on_req}, 32'h8);
        check({16'h0, off_req}, 32'h20);
        rd(`TCS_REG_REQ, v);
        check(v, 32'h00200008);
        rd(`TCS_REG_STAT, v);
        check(v, 32'h0);
        wr(`TCS_REG_REQ, 32'h8);
        rd(`TCS_REG_REQ, v);
        check(v, 32'h00200000);
        wr(`TCS_REG_TIME, 32'h010C3B3B);
        repeat (40) tick_once();
        rd(`TCS_REG_TIME, v);
        check(v, 32'h01010000);
    endtask

    task automatic t_buttons();
        @(posedge sys_clk);
        press_mask <= 5'h04;
        repeat (5) @(posedge sys_clk);
        tick_once();
        check({27'h0, btn_pressed}, 32'h0);
        tick_once();
        check({27'h0, btn_pressed}, 32'h4);
        rd(`TCS_REG_BTN, v);
        check(v, 32'h4);
        @(posedge sys_clk);
        press_mask <= 5'h00;
        tick_once();
        tick_once();
        check({27'h0, btn_pressed}, 32'h0);
    endtask

    task automatic t_dawn();
        wr(`TCS_REG_REQ, 32'hFFFFFFFF);
        st(6'h27, 8'h40);
        @(posedge sys_clk);
        dawn_detect <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check({off_req, on_req}, 32'h00800000);
    endtask

    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        press_mask = 5'h00;
        dawn_detect = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        n_mismatch = 0;
        checks = 0;
        cycles = 0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_period();
        t_cascade();
        t_buttons();
        t_dawn();
        report_and_stop();
    end
endmodule
